/* dtb_pkg.sv */
// Package for the detect threshold and dc-block register bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package dtb_pkg;
    // Printed offsets are register indexes, byte address is four times them
    localparam logic [3:0] IDX_THR_HIGH = 4'h7;
    localparam logic [3:0] IDX_THR_LOW = 4'h8;
    localparam logic [3:0] IDX_CHANNEL0_CONFIGURATION = 4'h9;
    localparam logic [3:0] IDX_DETECT_CTRL = 4'ha;
    localparam logic [11:0] ADDR_THR_HIGH = {6'h00, IDX_THR_HIGH, 2'h0};
    localparam logic [11:0] ADDR_THR_LOW = {6'h00, IDX_THR_LOW, 2'h0};
    localparam logic [11:0] ADDR_CHANNEL0_CONFIGURATION = {6'h00, IDX_CHANNEL0_CONFIGURATION, 2'h0};
    localparam logic [11:0] ADDR_DETECT_CTRL = {6'h00, IDX_DETECT_CTRL, 2'h0};
    // Field positions
    localparam int LOWER_MSB = 15;
    localparam int LOWER_LSB = 8;
    localparam int COEFF_MSB = 3;
    localparam int COEFF_LSB = 0;
    localparam int ENABLE_BIT = 0;
    // Reset values, bypass code and shift offset
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] COEFF_BYPASS = 4'h0;
    localparam logic [3:0] COEFF_SHIFT_BASE = 4'h1;
endpackage

/* dtb_regs.sv */
// Register bank: current-detect threshold, dc-block coefficient select,
// channel-0 configuration word and the detect enable.
// Assumes an APB master on ref_clk_i; all inputs share that clock.
`timescale 1ns/1ns
// What this block does
// - Sixteen-bit read/write upper threshold field, reset to zero.
// - Eight-bit read/write lower threshold field at bits 15:8 of word 8h.
// - Low threshold and dc-block word decoded at 8h, resets 0000h.
// - Four-bit read/write filter select at bits 3:0, reset 0000b.
// - Select code zero bypasses the high-pass filter entirely.
// - Nonzero code gives coefficient 2 to minus (code plus one).
// - Channel-0 configuration word decoded at 9h, resets 0000h.
// - High threshold word decoded at 7h, resets 0000h.
// - Threshold is used only while the detect enable bit is set.
module dtb_regs
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [23:0] detect_threshold_o,
    output logic overcurrent_watch_enable_o,
    output logic highpass_bypass_o,
    output logic [4:0] highpass_shift_o,
    output logic [15:0] channel0_configuration_o
);
    logic [15:0] detect_level_upper_reg;
    logic [7:0] detect_level_lower_reg;
    logic [3:0] highpass_coeff_select_reg;
    logic [15:0] channel0_configuration_reg;
    logic overcurrent_watch_enable_reg;
    logic [31:0] read_next;
    logic hit_next;
    logic wr_take;
    logic rd_setup;
    logic addr_mapped;

    // Write happens in the access phase; answer registered one cycle later.
    // A request counts until answered, so a setup lost to a low enable
    // still gets its answer one wait state later instead of hanging.
    assign wr_take = psel_i && penable_i && pwrite_i && pready_o && clk_en_i;
    assign rd_setup = psel_i && !pready_o && clk_en_i;

    // Addresses that own a word; anything else answers with an error
    assign addr_mapped = (paddr_i == dtb_pkg::ADDR_THR_HIGH) || (paddr_i == dtb_pkg::ADDR_THR_LOW)
        || (paddr_i == dtb_pkg::ADDR_CHANNEL0_CONFIGURATION) || (paddr_i == dtb_pkg::ADDR_DETECT_CTRL);

    // Address decode and read mux
    always_comb
    begin
        read_next = 32'h0000_0000;
        hit_next = 1'b1;
        unique case (paddr_i)
            dtb_pkg::ADDR_THR_HIGH: read_next = {16'h0000, detect_level_upper_reg};
            dtb_pkg::ADDR_THR_LOW: read_next = {16'h0000, detect_level_lower_reg,
                4'h0, highpass_coeff_select_reg};
            dtb_pkg::ADDR_CHANNEL0_CONFIGURATION: read_next = {16'h0000, channel0_configuration_reg};
            dtb_pkg::ADDR_DETECT_CTRL: read_next = {31'h0000_0000,
                overcurrent_watch_enable_reg};
            default: hit_next = 1'b0;
        endcase
    end

    // Upper threshold word
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            detect_level_upper_reg <= dtb_pkg::RST_WORD;
        else if (wr_take && paddr_i == dtb_pkg::ADDR_THR_HIGH)
            detect_level_upper_reg <= pwdata_i[15:0];
    end

    // Lower threshold and filter select; bits 7:4 not stored
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            detect_level_lower_reg <= 8'h00;
            highpass_coeff_select_reg <= dtb_pkg::COEFF_BYPASS;
        end
        else if (wr_take && paddr_i == dtb_pkg::ADDR_THR_LOW)
        begin
            detect_level_lower_reg <= pwdata_i[dtb_pkg::LOWER_MSB:dtb_pkg::LOWER_LSB];
            highpass_coeff_select_reg <= pwdata_i[dtb_pkg::COEFF_MSB:dtb_pkg::COEFF_LSB];
        end
    end

    // Channel-0 word and detect enable
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            channel0_configuration_reg <= dtb_pkg::RST_WORD;
            overcurrent_watch_enable_reg <= 1'b0;
        end
        else if (wr_take && paddr_i == dtb_pkg::ADDR_CHANNEL0_CONFIGURATION)
            channel0_configuration_reg <= pwdata_i[15:0];
        else if (wr_take && paddr_i == dtb_pkg::ADDR_DETECT_CTRL)
            overcurrent_watch_enable_reg <= pwdata_i[dtb_pkg::ENABLE_BIT];
    end

    // Bus answer: ready in the first cycle of the access phase
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else if (clk_en_i)
        begin
            pready_o <= rd_setup;
            pslverr_o <= rd_setup && !hit_next;
            if (rd_setup)
                prdata_o <= read_next;
        end
    end

    // Outputs to the datapath, all registered
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            detect_threshold_o <= 24'h00_0000;
            overcurrent_watch_enable_o <= 1'b0;
            highpass_bypass_o <= 1'b1;
            highpass_shift_o <= 5'h00;
            channel0_configuration_o <= 16'h0000;
        end
        else if (clk_en_i)
        begin
            // Threshold forced to zero while detect is disabled
            detect_threshold_o <= overcurrent_watch_enable_reg ?
                {detect_level_upper_reg, detect_level_lower_reg} : 24'h00_0000;
            overcurrent_watch_enable_o <= overcurrent_watch_enable_reg;
            highpass_bypass_o <= (highpass_coeff_select_reg == dtb_pkg::COEFF_BYPASS);
            highpass_shift_o <= {1'b0, highpass_coeff_select_reg}
                + {1'b0, dtb_pkg::COEFF_SHIFT_BASE};
            channel0_configuration_o <= channel0_configuration_reg;
        end
    end

    // Lower threshold byte taken from bits 15:8
    a_lower_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_take && paddr_i == dtb_pkg::ADDR_THR_LOW) |=>
        detect_level_lower_reg == $past(pwdata_i[15:8]))
        else $error("lower threshold not written");

    // Upper threshold word taken whole
    a_upper_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_take && paddr_i == dtb_pkg::ADDR_THR_HIGH) |=>
        detect_level_upper_reg == $past(pwdata_i[15:0]))
        else $error("upper threshold not written");

    // Low word reads back with reserved bits clear
    a_low_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_setup && paddr_i == dtb_pkg::ADDR_THR_LOW) |=>
        prdata_o[7:4] == 4'h0 && prdata_o[3:0] == highpass_coeff_select_reg && pready_o)
        else $error("low word readback wrong");

    // Filter select taken from bits 3:0
    a_coeff_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_take && paddr_i == dtb_pkg::ADDR_THR_LOW) |=>
        highpass_coeff_select_reg == $past(pwdata_i[3:0]))
        else $error("filter select not written");

    // Code zero takes the filter out of the path
    a_bypass_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && highpass_coeff_select_reg == 4'h0 |=> highpass_bypass_o)
        else $error("bypass missing for code zero");

    // Top code gives the smallest coefficient
    a_shift_code: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && highpass_coeff_select_reg == 4'hf |=> highpass_shift_o == 5'h10)
        else $error("shift for top code wrong");

    // Channel-0 word reads back without error
    a_ch0_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_setup && paddr_i == dtb_pkg::ADDR_CHANNEL0_CONFIGURATION) |=>
        prdata_o[15:0] == channel0_configuration_reg && !pslverr_o)
        else $error("channel0 readback wrong");

    // High threshold word reads back in the low half
    a_high_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_setup && paddr_i == dtb_pkg::ADDR_THR_HIGH) |=>
        prdata_o == {16'h0000, detect_level_upper_reg})
        else $error("high word readback wrong");

    // Threshold held at zero while detect is off
    a_disabled_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && !overcurrent_watch_enable_reg |=> detect_threshold_o == 24'h00_0000)
        else $error("threshold active while disabled");

    // Threshold is upper field above lower field
    a_concat_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && overcurrent_watch_enable_reg |=>
        detect_threshold_o == $past({detect_level_upper_reg, detect_level_lower_reg}))
        else $error("threshold concatenation wrong");

    // Answer comes the cycle after a request is seen
    a_ready_answer: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (psel_i && !penable_i && clk_en_i && !pready_o) |=> pready_o)
        else $error("no answer after setup");

    // Ready is a single-cycle pulse while clocked
    a_ready_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (pready_o && clk_en_i) |=> !pready_o)
        else $error("ready held too long");

    // Unmapped word answers with error and zero data
    a_unmapped_error: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_setup && !addr_mapped) |=> pslverr_o && prdata_o == 32'h0000_0000)
        else $error("unmapped access not refused");

    // Mapped words never flag an error
    a_mapped_okay: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_setup && addr_mapped) |=> !pslverr_o)
        else $error("error on mapped word");

    // Upper half of every answer reads zero
    a_upper_half: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pready_o |-> prdata_o[31:16] == 16'h0000)
        else $error("upper half of read data not zero");

    // Enable bit stored from bit 0 of its word
    a_enable_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_take && paddr_i == dtb_pkg::ADDR_DETECT_CTRL) |=>
        overcurrent_watch_enable_reg == $past(pwdata_i[0]))
        else $error("detect enable not written");

    // Enable output follows its register one cycle later
    a_enable_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i |=> overcurrent_watch_enable_o == $past(overcurrent_watch_enable_reg))
        else $error("enable output lags wrongly");

    // Any nonzero code keeps the filter in the path
    a_bypass_nonzero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && highpass_coeff_select_reg != 4'h0) |=> !highpass_bypass_o)
        else $error("filter bypassed for nonzero code");

    // Code one gives a coefficient of one quarter
    a_shift_quarter: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && highpass_coeff_select_reg == 4'h1) |=> highpass_shift_o == 5'h02)
        else $error("shift for code one wrong");

    // Each higher code halves the coefficient once more
    a_shift_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && highpass_coeff_select_reg != 4'h0) |=>
        highpass_shift_o == $past({1'b0, highpass_coeff_select_reg}) + 5'h01)
        else $error("shift does not track code");

    // Channel-0 word stored whole
    a_ch0_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_take && paddr_i == dtb_pkg::ADDR_CHANNEL0_CONFIGURATION) |=>
        channel0_configuration_reg == $past(pwdata_i[15:0]))
        else $error("channel0 word not written");

    // Channel-0 output copies its register
    a_ch0_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i |=> channel0_configuration_o == $past(channel0_configuration_reg))
        else $error("channel0 output lags wrongly");

    // Writes elsewhere leave the upper threshold alone
    a_upper_kept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_take && paddr_i != dtb_pkg::ADDR_THR_HIGH) |=> $stable(detect_level_upper_reg))
        else $error("upper threshold disturbed");

    // Reads never change the low word
    a_low_kept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (psel_i && penable_i && !pwrite_i && pready_o) |=>
        $stable(detect_level_lower_reg) && $stable(highpass_coeff_select_reg))
        else $error("low word changed by a read");

    // Writes to unmapped words are dropped
    a_unmapped_kept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_take && !addr_mapped) |=> $stable(detect_level_upper_reg)
            && $stable(detect_level_lower_reg) && $stable(highpass_coeff_select_reg)
            && $stable(channel0_configuration_reg) && $stable(overcurrent_watch_enable_reg))
        else $error("unmapped write changed a field");

    // Low enable freezes the stored fields
    a_freeze_fields: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !clk_en_i |=> $stable(detect_level_upper_reg) && $stable(detect_level_lower_reg)
            && $stable(highpass_coeff_select_reg) && $stable(channel0_configuration_reg)
            && $stable(overcurrent_watch_enable_reg))
        else $error("field changed while frozen");

    // Low enable freezes the outputs to the datapath
    a_freeze_outputs: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !clk_en_i |=> $stable(detect_threshold_o) && $stable(highpass_bypass_o)
            && $stable(highpass_shift_o) && $stable(channel0_configuration_o)
            && $stable(overcurrent_watch_enable_o))
        else $error("output changed while frozen");

    // Low enable freezes the bus answer
    a_freeze_bus: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !clk_en_i |=> $stable(pready_o) && $stable(pslverr_o) && $stable(prdata_o))
        else $error("bus answer changed while frozen");

    // Reset clears every stored field
    a_reset_fields: assert property (@(posedge ref_clk_i)
        rst_i |=> detect_level_upper_reg == 16'h0000 && detect_level_lower_reg == 8'h00
            && highpass_coeff_select_reg == 4'h0 && channel0_configuration_reg == 16'h0000
            && !overcurrent_watch_enable_reg)
        else $error("fields not cleared by reset");

    // Reset puts every output but highpass_shift_o at its idle value
    a_reset_outputs: assert property (@(posedge ref_clk_i)
        rst_i |=> !pready_o && !pslverr_o && prdata_o == 32'h0000_0000
            && detect_threshold_o == 24'h00_0000 && highpass_bypass_o
            && channel0_configuration_o == 16'h0000 && !overcurrent_watch_enable_o)
        else $error("outputs not idle after reset");
endmodule

/* tb.sv */
// Self-checking bench for the detect threshold and dc-block register bank.
// Assumes an APB slave answering with registered pready; clock enable driven here.
`timescale 1ns/1ns
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [23:0] thr;
    logic en;
    logic byp;
    logic [4:0] shift;
    logic [15:0] ch0;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int num_checks = 0;
    // Device under test
    dtb_regs i_dtb_regs (.ref_clk_i(ref_clk), .rst_i(rst), .clk_en_i(clk_en), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .detect_threshold_o(thr), .overcurrent_watch_enable_o(en),
        .highpass_bypass_o(byp), .highpass_shift_o(shift), .channel0_configuration_o(ch0));
    // Clock at 100 MHz
    always #5 ref_clk = ~ref_clk;
    // Compare any value up to one word
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask
    // Let register outputs settle after a write
    task settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    // Reset values of the threshold, filter and channel-0 words and the bypass, threshold and enable outputs
    task t_reset();
        settle();
        chk({31'h0, byp}, 32'h1);
        chk({8'h0, thr}, 32'h0);
        chk({31'h0, en}, 32'h0);
        apb(1'b0, dtb_pkg::ADDR_THR_HIGH, 32'h0); chk(rd, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, dtb_pkg::ADDR_THR_LOW, 32'h0); chk(rd, 32'h0);
        apb(1'b0, dtb_pkg::ADDR_CHANNEL0_CONFIGURATION, 32'h0); chk(rd, 32'h0);
        $display("test reset done");
    endtask
    // Field access, reserved bits, threshold gating and assembly
    task t_fields();
        apb(1'b1, dtb_pkg::ADDR_THR_HIGH, 32'hffffa5c3);
        apb(1'b0, dtb_pkg::ADDR_THR_HIGH, 32'h0); chk(rd, 32'h0000a5c3);
        apb(1'b1, dtb_pkg::ADDR_THR_LOW, 32'hffffc3f5);
        apb(1'b0, dtb_pkg::ADDR_THR_LOW, 32'h0); chk(rd, 32'h0000c305);
        settle();
        chk({8'h0, thr}, 32'h0);
        apb(1'b1, dtb_pkg::ADDR_DETECT_CTRL, 32'h1);
        settle();
        chk({8'h0, thr}, 32'h00a5c3c3);
        chk({31'h0, en}, 32'h1);
        apb(1'b0, dtb_pkg::ADDR_DETECT_CTRL, 32'h0); chk(rd, 32'h1);
        apb(1'b1, dtb_pkg::ADDR_CHANNEL0_CONFIGURATION, 32'h12345a6b);
        apb(1'b0, dtb_pkg::ADDR_CHANNEL0_CONFIGURATION, 32'h0); chk(rd, 32'h00005a6b);
        settle();
        chk({16'h0, ch0}, 32'h00005a6b);
        apb(1'b1, 12'h030, 32'hffffffff); chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h030, 32'h0); chk(rd, 32'h0);
        $display("test fields done");
    endtask
    // Every filter select code
    task t_codes();
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, dtb_pkg::ADDR_THR_LOW, {16'h0, 8'h5a, 4'h0, c[3:0]});
            apb(1'b0, dtb_pkg::ADDR_THR_LOW, 32'h0); chk(rd, {16'h0, 8'h5a, 4'h0, c[3:0]});
            settle();
            chk({31'h0, byp}, {31'h0, c == 0});
            if (c != 0) chk({27'h0, shift}, c + 1);
            chk({8'h0, thr}, 32'h00a5c35a);
        end
        $display("test codes done");
    endtask
    // Low clock enable holds outputs until it returns
    task t_freeze();
        apb(1'b1, dtb_pkg::ADDR_THR_HIGH, 32'h00003c5a);
        clk_en <= 1'b0;
        settle();
        chk({8'h0, thr}, 32'h00a5c35a);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        settle();
        chk({8'h0, thr}, 32'h003c5a5a);
        $display("test freeze done");
    endtask
    // Reset in mid-run clears every written word
    task t_midreset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        chk({8'h0, thr}, 32'h0);
        chk({31'h0, en}, 32'h0);
        chk({31'h0, byp}, 32'h1);
        chk({16'h0, ch0}, 32'h0);
        apb(1'b0, dtb_pkg::ADDR_THR_HIGH, 32'h0); chk(rd, 32'h0);
        apb(1'b0, dtb_pkg::ADDR_THR_LOW, 32'h0); chk(rd, 32'h0);
        apb(1'b0, dtb_pkg::ADDR_CHANNEL0_CONFIGURATION, 32'h0); chk(rd, 32'h0);
        $display("test mid-run reset done");
    endtask
    // Verdict and end of run
    task report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_codes();
        t_freeze();
        t_midreset();
        report_and_stop();
    end
    // Watchdog against a hung handshake
    initial
    begin
        #50000;
        error_cnt++;
        report_and_stop();
    end
endmodule
